// ==== verilog/mspdc_defines.vh ====
`ifndef MSPDC_DEFINES_VH
`define MSPDC_DEFINES_VH
// Register byte offsets
`define MSPDC_OFF_STRAP      8'h00
`define MSPDC_OFF_TEST       8'h04
`define MSPDC_OFF_AUX        8'h08
`define MSPDC_OFF_MISC       8'h0C
`define MSPDC_OFF_HOSTIO     8'h10
`define MSPDC_OFF_STATUS     8'h14
`define MSPDC_OFF_DRAMCMD    8'h18
`define MSPDC_OFF_DACDATA    8'h1C
// Strap field positions
`define MSPDC_STRAP_WSTYLE   17
`define MSPDC_STRAP_LOCAL    11
`define MSPDC_STRAP_CHAN     2
`define MSPDC_STRAP_WAKE     9
`define MSPDC_STRAP_ORG      16
`define MSPDC_STRAP_BLANK    18
`define MSPDC_STRAP_VCDIR    3
// Register field positions
`define MSPDC_TEST_MATRI     4
`define MSPDC_AUX_VC2        1
`define MSPDC_MISC_HPOL      6
`define MSPDC_MISC_VPOL      7
`define MSPDC_MISC_CS0       2
`define MSPDC_MISC_CS1       3
`define MSPDC_SENSE_BIT      4
// Reset values
`define MSPDC_TEST_RST       32'h00000000
`define MSPDC_AUX_RST        32'h00000000
`define MSPDC_MISC_RST       32'h00000000
// Misc output port and palette port window, I/O addresses
`define MSPDC_IO_MISC        16'h03C2
`define MSPDC_IO_PAL_LO      16'h03C6
`define MSPDC_IO_PAL_HI      16'h03C9
`define MSPDC_IO_PAL_GAP     16'h03C7
// Timing: reset hold in memory clocks, strobe width in aclk cycles
`define MSPDC_RESET_MCLKS    10
`define MSPDC_IO_PULSE       4'h4
`endif

// ==== verilog/mspdc_sync.v ====
`timescale 1ns/1ps
// Two-flop synchroniser, one per bit
module mspdc_sync #(
  parameter W = 1
) (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta;
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta <= {W{1'b0}};
      q    <= {W{1'b0}};
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // mspdc_sync

// ==== verilog/mspdc_top.v ====
// What this block does
// - Main row strobe for first megabyte; upper strobe only for second, two fitted.
// - Style strap 1: four byte write enables, one shared column strobe.
// - Style strap 0: four byte column strobes, single write enable for all bytes.
// - Test register bit 4 set tristates the nine DRAM address outputs.
// - Strap register keeps DRAM data lines sampled on the third edge after reset; undriven lines read one.
// - Strap bits 30 to 20 are ignored unless local bus mode selected.
// - Strap bit 11 selects expansion bus or local bus host operation.
// - Strap bit 2 selects expansion bus or channel bus host mode.
// - Strap bit 9 picks wake port 3C3h or 46E8h.
// - Strap bit 16 picks 64Kx16 or 256Kx4 DRAM organisation.
// - Strap 31:30 give I/O strobe timing, 29:28 and 27:26 memory timing.
// - Strap bit 18 turns the ROM select output into external blanking.
// - Palette converter uses a 3-bit address bus and 8-bit two-way data.
// - Palette read strobe low only during I/O reads of 3C6h, 3C8h, 3C9h.
// - Palette write strobe low during I/O writes of 3C6h through 3C9h.
// - Pixel clock taken from one of three video clocks by misc select bits while pins 1 and 2 are inputs.
// - Video clock pins 1 and 2 direction fixed together at reset by line 3.
// - Output pin 1 is a low pulse on 3C2h writes or misc bit 2.
// - Output pin 2 follows aux bit 1 or misc bit 2.
// - External video enable low tristates the eight pixel outputs.
// - External pixel clock enable low tristates the pixel clock output.
// - Sync polarities set independently by misc register bits.
// - Status register reads return the monitor sense level at bit 4.
`timescale 1ns/1ps
`include "mspdc_defines.vh"
module mspdc_top (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [31:0] dram_data_lines_i,
  input  wire        vid_clk_in_a,
  input  wire        vid_clk_pin_b_i,
  input  wire        vid_clk_pin_c_i,
  input  wire        ext_video_enable_n,
  input  wire        ext_pixclk_enable_n,
  input  wire        monitor_sense,
  input  wire [7:0]  pixel_in,
  input  wire        blank_in,
  input  wire        hsync_in,
  input  wire        vsync_in,
  input  wire [7:0]  dac_data_i,
  output reg         row_strobe_n,
  output reg         upper_meg_row_strobe_n,
  output reg  [3:0]  byte_strobe_n,
  output reg         shared_strobe_n,
  output reg         dram_oe_n,
  output reg  [8:0]  dram_addr_out,
  output reg         dram_addr_oe,
  output reg  [2:0]  dac_addr,
  output reg  [7:0]  dac_data_o,
  output reg         dac_data_oe,
  output reg         palette_read_strobe_n,
  output reg         palette_write_strobe_n,
  output reg  [7:0]  pixel_bus,
  output reg         pixel_bus_oe,
  output reg         blanking_out_n,
  output reg         pixclk_out,
  output reg         pixclk_oe,
  output reg         vid_clk_pin_b_o,
  output reg         vid_clk_pin_c_o,
  output reg         vid_clk_pins_oe,
  output reg         hsync_out,
  output reg         vsync_out,
  output reg         rom_select_out_n,
  output reg         host_local_bus,
  output reg         host_channel_bus,
  output reg         wake_port_alt,
  output reg         dram_org_x4,
  output reg  [1:0]  io_strobe_time,
  output reg  [1:0]  mem_high_time,
  output reg  [1:0]  mem_low_time
);
  // ==========================================================
  // Synchronisers for pins from outside the aclk domain
  // ==========================================================
  wire [31:0] md_s;
  wire [13:0] pin_s;
  wire [7:0]  dac_s;
  mspdc_sync #(.W(32)) u_sync_md (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (dram_data_lines_i),
    .q       (md_s)
  );
  mspdc_sync #(.W(14)) u_sync_pin (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({vid_clk_in_a, vid_clk_pin_b_i, vid_clk_pin_c_i, ext_video_enable_n,
               ext_pixclk_enable_n, monitor_sense, blank_in, hsync_in, vsync_in,
               5'h00}),
    .q       (pin_s)
  );
  mspdc_sync #(.W(8)) u_sync_dac (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (dac_data_i),
    .q       (dac_s)
  );
  wire vca_s   = pin_s[13];
  wire vcb_s   = pin_s[12];
  wire vcc_s   = pin_s[11];
  wire ext_video_enable_n_s = pin_s[10];
  wire expck_s = pin_s[9];
  wire sense_s = pin_s[8];
  wire blanking_out_s  = pin_s[7];
  wire hs_s    = pin_s[6];
  wire vs_s    = pin_s[5];

  // ==========================================================
  // Strap capture
  // ==========================================================
  // The line synchroniser is cleared by reset as well, so sampling runs on
  // for three edges after release, until the synchronised lines are real.
  // Board pull-ups make undriven lines 1.
  reg [31:0] strap_config;
  reg [1:0]  cap_cnt;
  always @(posedge aclk) begin
    if (!aresetn) begin
      cap_cnt      <= 2'h0;
      strap_config <= md_s;
    end else if (cap_cnt != 2'h3) begin
      cap_cnt      <= cap_cnt + 2'h1;
      strap_config <= md_s;
    end
  end
  wire local_mode = strap_config[`MSPDC_STRAP_LOCAL];
  wire [31:0] strap_eff = local_mode ? strap_config :
                          {strap_config[31], 11'h000, strap_config[19:0]};
  wire wstyle = strap_eff[`MSPDC_STRAP_WSTYLE];
  wire vc_out = strap_eff[`MSPDC_STRAP_VCDIR];

  // ==========================================================
  // Registers
  // ==========================================================
  reg [31:0] test_control_reg;
  reg [31:0] aux_control_reg;
  reg [31:0] misc_out_reg;
  reg [31:0] dram_cmd;
  reg [7:0]  dac_wr_data;
  reg        pulse_mode;

  // Write channel: address and data may come in either order
  reg        aw_held;
  reg        w_held;
  reg [7:0]  aw_addr;
  reg [31:0] w_data;
  reg [3:0]  w_strb;
  wire       aw_take = s_axi_awvalid && s_axi_awready;
  wire       w_take  = s_axi_wvalid && s_axi_wready;
  wire       aw_have = aw_held || aw_take;
  wire       w_have  = w_held || w_take;
  wire [7:0]  wa  = aw_held ? aw_addr : s_axi_awaddr[7:0];
  wire [31:0] wd  = w_held ? w_data : s_axi_wdata;
  wire [3:0]  ws  = w_held ? w_strb : s_axi_wstrb;
  wire        do_write = aw_have && w_have && !s_axi_bvalid;
  wire [31:0] wmask = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
  wire        wr_ok = (wa == `MSPDC_OFF_TEST) || (wa == `MSPDC_OFF_AUX) ||
                      (wa == `MSPDC_OFF_MISC) || (wa == `MSPDC_OFF_HOSTIO) ||
                      (wa == `MSPDC_OFF_DRAMCMD) || (wa == `MSPDC_OFF_DACDATA) ||
                      (wa == `MSPDC_OFF_STRAP) || (wa == `MSPDC_OFF_STATUS);
  // Host I/O request register: [15:0] port, [16] read, [17] write, [18] pulse mode
  wire        hio_wr = do_write && (wa == `MSPDC_OFF_HOSTIO) && ws[2];

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready    <= 1'b0;
      s_axi_wready     <= 1'b0;
      s_axi_bvalid     <= 1'b0;
      s_axi_bresp      <= 2'b00;
      aw_held          <= 1'b0;
      w_held           <= 1'b0;
      aw_addr          <= 8'h00;
      w_data           <= 32'h00000000;
      w_strb           <= 4'h0;
      test_control_reg <= `MSPDC_TEST_RST;
      aux_control_reg  <= `MSPDC_AUX_RST;
      misc_out_reg     <= `MSPDC_MISC_RST;
      dram_cmd         <= 32'h00000000;
      dac_wr_data      <= 8'h00;
      pulse_mode       <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have && !s_axi_bvalid;
      s_axi_wready  <= !w_have && !s_axi_bvalid;
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr[7:0];
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held       <= 1'b0;
        w_held        <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= wr_ok ? 2'b00 : 2'b10;
        case (wa)
          `MSPDC_OFF_TEST:
            test_control_reg <= (test_control_reg & ~wmask) | (wd & wmask);
          `MSPDC_OFF_AUX:
            aux_control_reg <= (aux_control_reg & ~wmask) | (wd & wmask);
          `MSPDC_OFF_MISC:
            misc_out_reg <= (misc_out_reg & ~wmask) | (wd & wmask);
          `MSPDC_OFF_DRAMCMD:
            dram_cmd <= (dram_cmd & ~wmask) | (wd & wmask);
          `MSPDC_OFF_DACDATA:
            if (ws[0])
              dac_wr_data <= wd[7:0];
          `MSPDC_OFF_HOSTIO:
            if (ws[2])
              pulse_mode <= wd[18];
          default: begin
          end
        endcase
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Host I/O cycle emulation toward the palette converter
  // ==========================================================
  reg [15:0] io_port;
  reg        io_rd;
  reg        io_wr;
  reg [3:0]  io_cnt;
  reg [7:0]  dac_rd_data;
  wire io_busy = (io_cnt != 4'h0);
  wire pal_rd_hit = (io_port == 16'h03C6) || (io_port == 16'h03C8) ||
                    (io_port == `MSPDC_IO_PAL_HI);
  wire pal_wr_hit = (io_port >= `MSPDC_IO_PAL_LO) && (io_port <= `MSPDC_IO_PAL_HI);
  always @(posedge aclk) begin
    if (!aresetn) begin
      io_port     <= 16'h0000;
      io_rd       <= 1'b0;
      io_wr       <= 1'b0;
      io_cnt      <= 4'h0;
      dac_rd_data <= 8'h00;
    end else if (hio_wr && !io_busy) begin
      io_port <= wd[15:0];
      io_rd   <= wd[16];
      io_wr   <= wd[17] && !wd[16];
      io_cnt  <= (wd[16] || wd[17]) ? `MSPDC_IO_PULSE : 4'h0;
    end else if (io_busy) begin
      io_cnt <= io_cnt - 4'h1;
      if (io_cnt == 4'h1) begin
        if (io_rd && pal_rd_hit)
          dac_rd_data <= dac_s;
        io_rd <= 1'b0;
        io_wr <= 1'b0;
      end
    end
  end

  // Read channel
  reg [31:0] rd_mux;
  always @* begin
    case (s_axi_araddr[7:0])
      `MSPDC_OFF_STRAP:   rd_mux = strap_config;
      `MSPDC_OFF_TEST:    rd_mux = test_control_reg;
      `MSPDC_OFF_AUX:     rd_mux = aux_control_reg;
      `MSPDC_OFF_MISC:    rd_mux = misc_out_reg;
      `MSPDC_OFF_HOSTIO:  rd_mux = {13'h0000, pulse_mode, io_wr, io_rd, io_port};
      `MSPDC_OFF_STATUS:  rd_mux = {15'h0000, io_busy, dac_rd_data, 3'h0,
                                    sense_s, 4'h0};
      `MSPDC_OFF_DRAMCMD: rd_mux = dram_cmd;
      `MSPDC_OFF_DACDATA: rd_mux = {24'h000000, dac_wr_data};
      default:            rd_mux = 32'h00000000;
    endcase
  end
  wire rd_ok = (s_axi_araddr[7:0] <= `MSPDC_OFF_DACDATA) && (s_axi_araddr[1:0] == 2'b00);
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_mux;
        s_axi_rresp   <= rd_ok ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // DRAM strobes; dram_cmd: [0] row, [1] col, [5:2] byte en, [6] write,
  // [7] upper meg, [8] two megs fitted, [9] oe, [24:16] address
  // ==========================================================
  wire       c_row = dram_cmd[0];
  wire       c_col = dram_cmd[1];
  wire [3:0] c_be  = dram_cmd[5:2];
  wire       c_wr  = dram_cmd[6];
  always @(posedge aclk) begin
    if (!aresetn) begin
      row_strobe_n           <= 1'b1;
      upper_meg_row_strobe_n <= 1'b1;
      byte_strobe_n          <= 4'hF;
      shared_strobe_n        <= 1'b1;
      dram_oe_n              <= 1'b1;
      dram_addr_out          <= 9'h000;
      dram_addr_oe           <= 1'b0;
    end else begin
      row_strobe_n           <= !(c_row && !dram_cmd[7]);
      upper_meg_row_strobe_n <= !(c_row && dram_cmd[7] && dram_cmd[8]);
      if (wstyle) begin
        byte_strobe_n   <= ~(c_be & {4{c_col && c_wr}});
        shared_strobe_n <= !c_col;
      end else begin
        byte_strobe_n   <= ~(c_be & {4{c_col}});
        shared_strobe_n <= !(c_col && c_wr);
      end
      dram_oe_n     <= !dram_cmd[9];
      dram_addr_out <= strap_eff[`MSPDC_STRAP_ORG] ? dram_cmd[24:16] :
                       {1'b0, dram_cmd[23:16]};
      dram_addr_oe  <= !test_control_reg[`MSPDC_TEST_MATRI];
    end
  end

  // ==========================================================
  // Palette converter pins and strap-decoded outputs
  // ==========================================================
  always @(posedge aclk) begin
    if (!aresetn) begin
      dac_addr               <= 3'h0;
      dac_data_o             <= 8'h00;
      dac_data_oe            <= 1'b0;
      palette_read_strobe_n  <= 1'b1;
      palette_write_strobe_n <= 1'b1;
      host_local_bus         <= 1'b0;
      host_channel_bus       <= 1'b0;
      wake_port_alt          <= 1'b0;
      dram_org_x4            <= 1'b0;
      io_strobe_time         <= 2'b00;
      mem_high_time          <= 2'b00;
      mem_low_time           <= 2'b00;
    end else begin
      dac_addr               <= io_port[2:0];
      dac_data_o             <= dac_wr_data;
      dac_data_oe            <= io_wr && pal_wr_hit;
      palette_read_strobe_n  <= !(io_rd && pal_rd_hit);
      palette_write_strobe_n <= !(io_wr && pal_wr_hit);
      host_local_bus         <= local_mode;
      host_channel_bus       <= strap_eff[`MSPDC_STRAP_CHAN];
      wake_port_alt          <= strap_eff[`MSPDC_STRAP_WAKE];
      dram_org_x4            <= strap_eff[`MSPDC_STRAP_ORG];
      io_strobe_time         <= {strap_eff[31], strap_eff[30]};
      mem_high_time          <= strap_eff[29:28];
      mem_low_time           <= strap_eff[27:26];
    end
  end

  // ==========================================================
  // Video clock select and pixel side
  // ==========================================================
  wire [1:0] csel = {misc_out_reg[`MSPDC_MISC_CS1], misc_out_reg[`MSPDC_MISC_CS0]};
  // With pins b and c driven out they are not clock sources; only input a remains
  reg  sel_clk;
  always @* begin
    case (csel)
      2'b00:   sel_clk = vca_s;
      2'b01:   sel_clk = vc_out ? vca_s : vcb_s;
      2'b10:   sel_clk = vc_out ? vca_s : vcc_s;
      default: sel_clk = vca_s;
    endcase
  end
  reg sel_clk_d;
  wire pix_rise = sel_clk && !sel_clk_d;
  wire misc_io_wr = io_wr && (io_port == `MSPDC_IO_MISC);
  always @(posedge aclk) begin
    if (!aresetn) begin
      sel_clk_d       <= 1'b0;
      pixclk_out      <= 1'b0;
      pixclk_oe       <= 1'b0;
      pixel_bus       <= 8'h00;
      pixel_bus_oe    <= 1'b0;
      blanking_out_n  <= 1'b1;
      rom_select_out_n <= 1'b1;
      vid_clk_pin_b_o <= 1'b1;
      vid_clk_pin_c_o <= 1'b0;
      vid_clk_pins_oe <= 1'b0;
      hsync_out       <= 1'b0;
      vsync_out       <= 1'b0;
    end else begin
      sel_clk_d  <= sel_clk;
      pixclk_out <= sel_clk;
      pixclk_oe  <= expck_s;
      if (pix_rise) begin
        pixel_bus      <= pixel_in;
        blanking_out_n <= !blanking_out_s;
      end
      pixel_bus_oe <= ext_video_enable_n_s;
      rom_select_out_n <= strap_eff[`MSPDC_STRAP_BLANK] ? blanking_out_n :
                          !io_rd;
      vid_clk_pins_oe <= vc_out;
      vid_clk_pin_b_o <= pulse_mode ? !misc_io_wr :
                         misc_out_reg[`MSPDC_MISC_CS0];
      vid_clk_pin_c_o <= pulse_mode ? aux_control_reg[`MSPDC_AUX_VC2] :
                         misc_out_reg[`MSPDC_MISC_CS0];
      hsync_out <= hs_s ^ misc_out_reg[`MSPDC_MISC_HPOL];
      vsync_out <= vs_s ^ misc_out_reg[`MSPDC_MISC_VPOL];
    end
  end
endmodule // mspdc_top

// ==== dv/mspdc_props.sv ====
`timescale 1ns/1ps
module mspdc_props (
  input wire       aclk,
  input wire       aresetn,
  input wire       ext_video_enable_n,
  input wire       ext_pixclk_enable_n,
  input wire [2:0] dac_addr,
  input wire       dac_data_oe,
  input wire       palette_read_strobe_n,
  input wire       palette_write_strobe_n,
  input wire       pixel_bus_oe,
  input wire       pixclk_oe,
  input wire       row_strobe_n,
  input wire       upper_meg_row_strobe_n,
  input wire       host_local_bus,
  input wire [1:0] io_strobe_time,
  input wire [1:0] mem_high_time,
  input wire [1:0] mem_low_time
);
  // ==========================================================
  // Checks
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Straps settle a few edges after release; judge them only later
  reg [2:0] up_cnt;
  always @(posedge aclk)
    if (!aresetn) up_cnt <= 3'h0;
    else if (up_cnt != 3'h6) up_cnt <= up_cnt + 3'h1;
  property p_vid_tri; $fell(ext_video_enable_n) |-> ##[1:4] !pixel_bus_oe; endproperty
  a_vid_tri: assert property (p_vid_tri) else $error("pixel bus still driven");
  property p_clk_tri; !ext_pixclk_enable_n [*4] |-> !pixclk_oe; endproperty
  a_clk_tri: assert property (p_clk_tri) else $error("pixel clock still driven");
  property p_rd_port;
    !palette_read_strobe_n |-> dac_addr inside {3'h6, 3'h0, 3'h1} && palette_write_strobe_n;
  endproperty
  a_rd_port: assert property (p_rd_port) else $error("read strobe on wrong port");
  property p_wr_port;
    !palette_write_strobe_n |-> dac_data_oe && dac_addr inside {3'h6, 3'h7, 3'h0, 3'h1};
  endproperty
  a_wr_port: assert property (p_wr_port) else $error("write strobe on wrong port");
  property p_rd_len;
    $fell(palette_read_strobe_n) |-> !palette_read_strobe_n [*3] ##[1:3] palette_read_strobe_n;
  endproperty
  a_rd_len: assert property (p_rd_len) else $error("read strobe length wrong");
  property p_upper; !upper_meg_row_strobe_n |-> row_strobe_n; endproperty
  a_upper: assert property (p_upper) else $error("both row strobes low");
  property p_hold;
    up_cnt == 3'h6 |-> $stable({host_local_bus, io_strobe_time, mem_high_time, mem_low_time});
  endproperty
  a_hold: assert property (p_hold) else $error("strap decode changed");
  property p_ignore;
    up_cnt == 3'h6 && !host_local_bus |-> {io_strobe_time[0], mem_high_time, mem_low_time} == 5'h00;
  endproperty
  a_ignore: assert property (p_ignore) else $error("upper strap bits used");
  c_wr: cover property (!palette_write_strobe_n);
  c_rd: cover property (!palette_read_strobe_n);
  c_local: cover property (up_cnt == 3'h6 && host_local_bus);
endmodule // mspdc_props

bind mspdc_top mspdc_props mspdc_props_i (.*);

// ==== dv/mspdc_partner.sv ====
`timescale 1ns/1ps
module mspdc_partner (
  input  wire [31:0] strap_pulldown,
  input  wire [2:0]  dac_addr,
  input  wire [7:0]  dac_data_o,
  input  wire        dac_data_oe,
  input  wire        palette_read_strobe_n,
  input  wire        palette_write_strobe_n,
  output wire [31:0] dram_data_lines_i,
  output reg  [7:0]  dac_data_i,
  output reg         vid_clk_in_a
);
  // ==========================================================
  // Strap resistors and palette converter
  reg [7:0] pal [0:7];
  reg [7:0] last = 8'h00;
  // Weak pull-ups: only lines with a pull-down read low
  assign dram_data_lines_i = ~strap_pulldown;
  initial vid_clk_in_a = 1'b0;
  always #62.5 vid_clk_in_a = ~vid_clk_in_a;
  always @(negedge palette_write_strobe_n) begin
    #1;
    if (dac_data_oe) pal[dac_addr] = dac_data_o;
  end
  // Released bus has no pull: show the inverse so a late sample is caught
  always @* begin
    if (!palette_read_strobe_n) begin
      dac_data_i = pal[dac_addr];
      last = pal[dac_addr];
    end else
      dac_data_i = ~last;
  end
endmodule // mspdc_partner

// ==== dv/mspdc_top_tb.sv ====
`timescale 1ns/1ps
module mspdc_top_tb;
  reg         aclk = 1'b0, aresetn = 1'b0, monitor_sense = 1'b0, hsync_in = 1'b0;
  reg         vsync_in = 1'b0, ext_video_enable_n = 1'b1, ext_pixclk_enable_n = 1'b1;
  reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  reg  [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  reg  [31:0] strap_pulldown = 32'h0;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp, io_strobe_time, mem_high_time, mem_low_time;
  wire [31:0] s_axi_rdata, dram_data_lines_i;
  wire [7:0]  dac_data_i, dac_data_o;
  wire [2:0]  dac_addr;
  wire        vid_clk_in_a, dac_data_oe, palette_read_strobe_n, palette_write_strobe_n;
  wire        pixel_bus_oe, pixclk_oe, vid_clk_pins_oe, hsync_out, vsync_out, dram_addr_oe;
  wire        host_local_bus, host_channel_bus, wake_port_alt, dram_org_x4;
  wire        row_strobe_n, upper_meg_row_strobe_n, shared_strobe_n;
  wire [3:0]  byte_strobe_n;
  integer     miscompares = 0, total_checks = 0, cyc = 0;
  mspdc_top mspdc_top_i (.*, .s_axi_wstrb(4'hF), .vid_clk_pin_b_i(vid_clk_in_a),
    .vid_clk_pin_c_i(vid_clk_in_a), .pixel_in(8'h5A), .blank_in(1'b0), .dram_oe_n(),
    .dram_addr_out(), .pixel_bus(), .blanking_out_n(), .pixclk_out(), .vid_clk_pin_b_o(),
    .vid_clk_pin_c_o(), .rom_select_out_n());
  mspdc_partner mspdc_partner_i (.*);
  // ==========================================================
  // Clock, timeout, verdict
  always #2.5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      end_sim;
    end
  end
  task end_sim;
    begin
      if (miscompares == 0 && total_checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("mismatch %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // ==========================================================
  // Bus tasks
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    reg aw, w;
    begin
      @(posedge aclk);
      aw = 1'b1;
      w = 1'b1;
      s_axi_awaddr <= {24'h0, a};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (aw || w) begin
        @(posedge aclk);
        if (aw && s_axi_awready) begin
          aw = 1'b0;
          s_axi_awvalid <= 1'b0;
        end
        if (w && s_axi_wready) begin
          w = 1'b0;
          s_axi_wvalid <= 1'b0;
        end
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      chk(s_axi_bresp, er);
      s_axi_bready <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, output [31:0] d, output [1:0] r);
    begin
      @(posedge aclk);
      s_axi_araddr <= {24'h0, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask
  task rdchk(input [7:0] a, input [31:0] m, input [31:0] e, input [1:0] er);
    reg [31:0] d;
    reg [1:0] r;
    begin
      rd(a, d, r);
      chk(d & m, e);
      chk(r, er);
    end
  endtask
  // Emulated host I/O cycle; wait until the busy flag drops
  task io(input [15:0] p, input [1:0] k);
    reg [31:0] d;
    reg [1:0] r;
    begin
      wr(8'h10, {14'h0, k, p}, 2'b00);
      d = 32'h10000;
      while (d[16]) rd(8'h14, d, r);
    end
  endtask
  // ==========================================================
  // Scenarios
  task t_strap(input [31:0] m);
    reg [31:0] e;
    begin
      strap_pulldown <= m;
      aresetn <= 1'b0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      strap_pulldown <= ~m;
      e = ~m;
      rdchk(8'h00, 32'hFFFFFFFF, e, 2'b00);
      if (!e[11]) e[30:20] = 11'h0;
      chk(host_local_bus, e[11]);
      chk(host_channel_bus, e[2]);
      chk(wake_port_alt, e[9]);
      chk(dram_org_x4, e[16]);
      chk({io_strobe_time, mem_high_time, mem_low_time}, e[31:26]);
      chk(vid_clk_pins_oe, e[3]);
    end
  endtask
  task t_regs;
    begin
      rdchk(8'h04, 32'hFFFFFFFF, 32'h0, 2'b00);
      rdchk(8'h0C, 32'hFFFFFFFF, 32'h0, 2'b00);
      rdchk(8'h20, 32'hFFFFFFFF, 32'h0, 2'b10);
      wr(8'h20, 32'h1, 2'b10);
      wr(8'h04, 32'h10, 2'b00);
      wr(8'h18, 32'h187, 2'b00);
      repeat (4) @(posedge aclk);
      chk(dram_addr_oe, 1'b0);
      chk({row_strobe_n, upper_meg_row_strobe_n, byte_strobe_n, shared_strobe_n}, 7'b1011110);
    end
  endtask
  task t_pal;
    integer i;
    begin
      for (i = 6; i < 10; i = i + 1) begin
        wr(8'h1C, 32'hA0 + i, 2'b00);
        io(16'h03C0 + i, 2'b10);
      end
      io(16'h03C5, 2'b10);
      for (i = 6; i < 10; i = i + 1) begin
        io(16'h03C0 + i, 2'b01);
        if (i != 7) rdchk(8'h14, 32'hFF10, (32'hA0 + i) << 8, 2'b00);
      end
    end
  endtask
  task t_pins;
    begin
      monitor_sense <= 1'b1;
      repeat (4) @(posedge aclk);
      rdchk(8'h14, 32'h10, 32'h10, 2'b00);
      wr(8'h0C, 32'h40, 2'b00);
      repeat (6) @(posedge aclk);
      chk({hsync_out, vsync_out}, 2'b10);
      wr(8'h0C, 32'h80, 2'b00);
      repeat (6) @(posedge aclk);
      chk({hsync_out, vsync_out}, 2'b01);
      ext_video_enable_n <= 1'b0;
      ext_pixclk_enable_n <= 1'b0;
      repeat (6) @(posedge aclk);
      chk({pixel_bus_oe, pixclk_oe}, 2'b00);
    end
  endtask
  initial begin
    t_strap(32'h0000_0804);
    t_strap(32'h4401_0208);
    t_regs;
    t_pal;
    t_pins;
    end_sim;
  end
endmodule // mspdc_top_tb
